// ### shared/ptc_pkg.sv
// Constants and types for the player transport control block
package ptc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int POS_TICK_NS = 1000000;
   localparam int MS_CYCLES = POS_TICK_NS / CLK_PERIOD_NS;
   localparam int FF_SPEED = 2;
   localparam int TEXT_IN_CHARS = 16;
   localparam int NAME_CHARS = 11;
   localparam int STATE_CHARS = 8;
   localparam int TIME_DIGITS = 6;
   localparam logic [2:0] CODE_FIRST = 3'h0;
   localparam logic [2:0] CODE_LAST = 3'h6;
   localparam logic [23:0] POS_ZERO = 24'h000000;
   localparam logic [7:0] TRACK_FIRST = 8'h00;
   localparam logic [63:0] TXT_IDLE = "IDLE    ";
   localparam logic [63:0] TXT_PLAY = "PLAY    ";
   localparam logic [63:0] TXT_RPT = "REPEAT  ";
   localparam logic [63:0] TXT_FF = "FAST FWD";
   localparam logic [63:0] TXT_REV = "REVERSE ";

   typedef enum logic [2:0] {
      ACT_UP = 3'h0,
      ACT_DOWN = 3'h1,
      ACT_PLAY = 3'h2,
      ACT_RPT = 3'h3,
      ACT_FF = 3'h4,
      ACT_REV = 3'h5,
      ACT_STOP = 3'h6
   } ptc_act_t;

   typedef enum logic [1:0] {
      SEL_SONG = 2'h0,
      SEL_DIR = 2'h1,
      SEL_LIST = 2'h2
   } ptc_sel_t;

   typedef struct packed {
      logic [7:0] track_count;
      logic [23:0] track_len;
      ptc_sel_t sel_kind;
      logic [8*TEXT_IN_CHARS-1:0] artist;
      logic [8*TEXT_IN_CHARS-1:0] title;
   } ptc_meta_t;

   typedef struct packed {
      logic [2:0] code;
      logic [8*STATE_CHARS-1:0] state_txt;
      logic [8*NAME_CHARS-1:0] artist;
      logic [8*NAME_CHARS-1:0] title;
      logic [4*TIME_DIGITS-1:0] time_ms;
   } ptc_disp_t;
endpackage

// ### rtl/ptc_transport.sv
// Transport control state machine with selector input and display fields
`timescale 1ns/100ps
`default_nettype none

module ptc_transport
   import ptc_pkg::*;
#(
   parameter int MS_CNT = MS_CYCLES,
   parameter int SPEED = FF_SPEED
)
(
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic rot_fwd_pin, // Selector step forward, level toggles per detent
   input wire logic rot_back_pin, // Selector step backward, level toggles per detent
   input wire logic press_pin, // Selector press, high while pressed
   input wire ptc_meta_t meta, // Current selection data
   output ptc_disp_t disp, // Display fields
   output logic [2:0] state_code, // Transport state number
   output logic [7:0] track, // Selected track index
   output logic [23:0] pos_ms, // Track position, BCD ms
   output logic audio_en, // Audio produced
   output logic enter_dir, // Pulse: open selected directory
   output logic activate_list // Pulse: selected playlist made active
);
   typedef enum logic [2:0] {ST_IDLE, ST_PLAY, ST_RPT, ST_FF, ST_REV} ptc_state_t;

   localparam int FAST_CNT = (MS_CNT / SPEED < 1) ? 1 : MS_CNT / SPEED;
   localparam int CW = $clog2(MS_CNT + 1);

   function automatic logic [23:0] bcd_step(input logic [23:0] v, input logic up);
      logic [23:0] r;
      logic carry;
      r = v;
      carry = 1'b1;
      for (int i = 0; i < TIME_DIGITS; i++)
      begin
         if (carry)
         begin
            if (up)
            begin
               carry = (r[4*i +: 4] == 4'h9);
               r[4*i +: 4] = carry ? 4'h0 : r[4*i +: 4] + 4'h1;
            end
            else
            begin
               carry = (r[4*i +: 4] == 4'h0);
               r[4*i +: 4] = carry ? 4'h9 : r[4*i +: 4] - 4'h1;
            end
         end
      end
      return r;
   endfunction

   logic [2:0] sync_fwd, sync_back, sync_press;
   ptc_state_t state, next_state;
   logic [2:0] code;
   logic [CW-1:0] tick_cnt;
   logic [23:0] next_pos;
   logic [7:0] next_track;

   // Second stage feeds third stage only for edge detection
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_fwd <= 3'h0;
         sync_back <= 3'h0;
         sync_press <= 3'h0;
      end
      else
      begin
         sync_fwd <= {sync_fwd[1:0], rot_fwd_pin};
         sync_back <= {sync_back[1:0], rot_back_pin};
         sync_press <= {sync_press[1:0], press_pin};
      end
   end

   wire step_fwd = sync_fwd[1] ^ sync_fwd[2];
   wire step_back = sync_back[1] ^ sync_back[2];
   wire press_ev = sync_press[1] & ~sync_press[2];
   wire ptc_act_t act = ptc_act_t'(code);
   wire moving = (state == ST_FF) || (state == ST_REV);
   wire playing = (state == ST_PLAY) || (state == ST_RPT);
   wire [CW-1:0] tick_last = moving ? CW'(FAST_CNT - 1) : CW'(MS_CNT - 1);
   wire tick = (tick_cnt >= tick_last);
   wire at_end = (pos_ms == meta.track_len);
   wire at_start = (pos_ms == POS_ZERO);
   wire [7:0] last_track = meta.track_count - 8'h01;
   wire is_song = (meta.sel_kind == SEL_SONG);
   wire do_act = press_ev && (state == ST_IDLE);
   wire ptc_act_t idle_act = act;

   wire [2:0] code_up = (code == CODE_LAST) ? CODE_FIRST : code + 3'h1;
   wire [2:0] code_dn = (code == CODE_FIRST) ? CODE_LAST : code - 3'h1;
   wire [7:0] trk_up = (track >= last_track) ? TRACK_FIRST : track + 8'h01;
   wire [7:0] trk_dn = (track == TRACK_FIRST) ? last_track : track - 8'h01;

   // Next state from the pressed action and the end conditions
   always_comb
   begin
      next_state = state;
      if (press_ev)
      begin
         case (state)
            ST_IDLE:
            begin
               case (act)
                  ACT_PLAY: next_state = is_song ? ST_PLAY : ST_IDLE;
                  ACT_RPT: next_state = ST_RPT;
                  ACT_FF: next_state = ST_FF;
                  ACT_REV: next_state = ST_REV;
                  default: next_state = ST_IDLE;
               endcase
            end
            ST_PLAY, ST_RPT:
            begin
               case (act)
                  ACT_PLAY: next_state = ST_PLAY;
                  ACT_RPT: next_state = ST_RPT;
                  ACT_FF: next_state = ST_FF;
                  ACT_REV: next_state = ST_REV;
                  ACT_STOP: next_state = ST_IDLE;
                  default: next_state = state;
               endcase
            end
            ST_FF, ST_REV:
            begin
               case (act)
                  ACT_PLAY: next_state = ST_PLAY;
                  ACT_RPT: next_state = ST_RPT;
                  ACT_FF: next_state = (state == ST_FF) ? ST_IDLE : ST_FF;
                  ACT_REV: next_state = (state == ST_REV) ? ST_IDLE : ST_REV;
                  ACT_STOP: next_state = ST_IDLE;
                  default: next_state = state;
               endcase
            end
            default: next_state = ST_IDLE;
         endcase
      end
      else
      begin
         case (state)
            ST_PLAY: next_state = at_end ? ST_IDLE : ST_PLAY;
            ST_FF: next_state = at_end ? ST_IDLE : ST_FF;
            ST_REV: next_state = at_start ? ST_IDLE : ST_REV;
            default: next_state = state;
         endcase
      end
   end

   // Position: rewinds on stop from idle, play or repeat, on track change and repeat loop; steps on ticks
   always_comb
   begin
      next_pos = pos_ms;
      next_track = track;
      if (do_act && (idle_act == ACT_UP))
      begin
         next_track = trk_up;
         next_pos = POS_ZERO;
      end
      else if (do_act && (idle_act == ACT_DOWN))
      begin
         next_track = trk_dn;
         next_pos = POS_ZERO;
      end
      else if (do_act && (idle_act == ACT_STOP))
         next_pos = POS_ZERO;
      else if (press_ev && playing && (act == ACT_STOP))
         next_pos = POS_ZERO;
      else if (press_ev)
         next_pos = pos_ms;
      else if ((state == ST_RPT) && at_end)
         next_pos = POS_ZERO;
      else if (tick && (state == ST_RPT || state == ST_PLAY || state == ST_FF) && !at_end)
         next_pos = bcd_step(pos_ms, 1'b1);
      else if (tick && (state == ST_REV) && !at_start)
         next_pos = bcd_step(pos_ms, 1'b0);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         code <= CODE_FIRST;
      else if (step_fwd && !step_back)
         code <= code_up;
      else if (step_back && !step_fwd)
         code <= code_dn;
   end

   // Fast states use a shorter tick period for double speed
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt <= '0;
      else if (tick || press_ev)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + CW'(1);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         pos_ms <= POS_ZERO;
         track <= TRACK_FIRST;
         audio_en <= 1'b0;
         enter_dir <= 1'b0;
         activate_list <= 1'b0;
      end
      else
      begin
         state <= next_state;
         pos_ms <= next_pos;
         track <= next_track;
         audio_en <= (next_state == ST_PLAY) || (next_state == ST_RPT);
         enter_dir <= do_act && (idle_act == ACT_PLAY) && (meta.sel_kind == SEL_DIR);
         activate_list <= do_act && (idle_act == ACT_PLAY) && (meta.sel_kind == SEL_LIST);
      end
   end

   wire [63:0] state_txt = (state == ST_PLAY) ? TXT_PLAY :
                           (state == ST_RPT) ? TXT_RPT :
                           (state == ST_FF) ? TXT_FF :
                           (state == ST_REV) ? TXT_REV : TXT_IDLE;
   wire [8*NAME_CHARS-1:0] title_cut = meta.title[8*TEXT_IN_CHARS-1 -: 8*NAME_CHARS];
   wire [8*NAME_CHARS-1:0] artist_cut = meta.artist[8*TEXT_IN_CHARS-1 -: 8*NAME_CHARS];

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         disp <= '0;
         state_code <= 3'h0;
      end
      else
      begin
         disp <= {code, state_txt, artist_cut, title_cut, pos_ms};
         state_code <= 3'(state);
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   code_wrap_a: assert property ((step_fwd && !step_back && code == CODE_LAST) |=> code == CODE_FIRST)
      else $error("code did not wrap forward");
   code_back_a: assert property ((step_back && !step_fwd && code == CODE_FIRST) |=> code == CODE_LAST)
      else $error("code did not wrap backward");
   idle_wait_a: assert property ((state == ST_IDLE && !press_ev) |=> state == ST_IDLE)
      else $error("idle left without press");
   up_wrap_a: assert property ((do_act && act == ACT_UP && track == last_track) |=> track == TRACK_FIRST)
      else $error("track up did not wrap");
   down_wrap_a: assert property ((do_act && act == ACT_DOWN && track == TRACK_FIRST) |=>
      track == $past(last_track))
      else $error("track down did not wrap");
   play_ignore_a: assert property ((press_ev && state == ST_PLAY && code <= 3'h2) |=>
      state == ST_PLAY && $stable(track))
      else $error("play state reacted to ignored action");
   play_stop_a: assert property ((press_ev && playing && act == ACT_STOP) |=>
      state == ST_IDLE && pos_ms == POS_ZERO ##1 !audio_en)
      else $error("stop did not halt and rewind");
   ff_start_a: assert property ((press_ev && state == ST_PLAY && act == ACT_FF) |=>
      state == ST_FF && !audio_en)
      else $error("fast forward not entered silently");
   ff_end_a: assert property ((state == ST_FF && at_end && !press_ev) |=> state == ST_IDLE)
      else $error("fast forward passed track end");
   rev_end_a: assert property ((state == ST_REV && at_start && !press_ev) |=> state == ST_IDLE)
      else $error("reverse passed track start");
   rpt_cancel_a: assert property ((press_ev && state == ST_RPT && act == ACT_PLAY) |=> state == ST_PLAY)
      else $error("repeat not cancelled by play");
   disp_code_a: assert property (1'b1 |=> disp.code == $past(code))
      else $error("display code lags");
   list_pulse_a: assert property ((do_act && act == ACT_PLAY && meta.sel_kind == SEL_LIST) |=>
      activate_list && state == ST_IDLE)
      else $error("playlist press left idle or gave no pulse");
   idle_stop_a: assert property ((do_act && act == ACT_STOP) |=> pos_ms == POS_ZERO)
      else $error("idle stop did not rewind");

   play_end_c: cover property (state == ST_PLAY && at_end ##1 state == ST_IDLE);
   rpt_loop_c: cover property (state == ST_RPT && at_end ##1 pos_ms == POS_ZERO);
   rev_run_c: cover property (state == ST_REV && tick ##1 state == ST_REV);
   list_c: cover property (activate_list);
   dir_c: cover property (enter_dir);
endmodule

`default_nettype wire

// ### tb/ptc_user_model.sv
// Behavioural rotary selector operated by the bench
`timescale 1ns/100ps
`default_nettype none
module ptc_user_model
(
   input wire logic ref_clk, // Clock
   output logic rot_fwd_pin, // Forward detent level
   output logic rot_back_pin, // Backward detent level
   output logic press_pin // Push button, high pressed
);
   initial
   begin
      rot_fwd_pin = 1'b0;
      rot_back_pin = 1'b0;
      press_pin = 1'b0;
   end
   // One detent; the gap keeps toggles well apart
   task automatic step(input logic fwd);
      @(posedge ref_clk);
      if (fwd)
      begin
         rot_fwd_pin <= ~rot_fwd_pin;
      end
      else
      begin
         rot_back_pin <= ~rot_back_pin;
      end
      repeat (2) @(posedge ref_clk);
   endtask
   // Opposite detents in one cycle cancel out
   task automatic both();
      @(posedge ref_clk);
      rot_fwd_pin <= ~rot_fwd_pin;
      rot_back_pin <= ~rot_back_pin;
      repeat (2) @(posedge ref_clk);
   endtask
   // Press held four cycles, then released long enough for the next one
   task automatic push();
      @(posedge ref_clk);
      press_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      press_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the transport control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import ptc_pkg::*;
   typedef struct {ptc_act_t act; logic [2:0] st; logic au; logic [7:0] trk;} ptc_row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic rot_fwd_pin, rot_back_pin, press_pin, audio_en, enter_dir, activate_list;
   ptc_meta_t meta;
   ptc_disp_t disp;
   logic [2:0] state_code;
   logic [7:0] track;
   logic [23:0] pos_ms;
   int n_errors = 0, total_checks = 0, cyc = 0, cur = 0, n_dir = 0, n_list = 0, per;
   logic [63:0] txt [5] = '{TXT_IDLE, TXT_PLAY, TXT_RPT, TXT_FF, TXT_REV};
   ptc_row_t rows [18] = '{
      '{ACT_UP, 3'h0, 1'b0, 8'h01}, '{ACT_UP, 3'h0, 1'b0, 8'h02}, '{ACT_UP, 3'h0, 1'b0, 8'h00},
      '{ACT_DOWN, 3'h0, 1'b0, 8'h02}, '{ACT_PLAY, 3'h1, 1'b1, 8'h02}, '{ACT_UP, 3'h1, 1'b1, 8'h02},
      '{ACT_PLAY, 3'h1, 1'b1, 8'h02}, '{ACT_FF, 3'h3, 1'b0, 8'h02}, '{ACT_REV, 3'h4, 1'b0, 8'h02},
      '{ACT_REV, 3'h0, 1'b0, 8'h02}, '{ACT_RPT, 3'h2, 1'b1, 8'h02}, '{ACT_PLAY, 3'h1, 1'b1, 8'h02},
      '{ACT_RPT, 3'h2, 1'b1, 8'h02}, '{ACT_STOP, 3'h0, 1'b0, 8'h02}, '{ACT_FF, 3'h3, 1'b0, 8'h02},
      '{ACT_STOP, 3'h0, 1'b0, 8'h02}, '{ACT_PLAY, 3'h1, 1'b1, 8'h02}, '{ACT_STOP, 3'h0, 1'b0, 8'h02}};
   always #5 ref_clk = ~ref_clk;
   ptc_user_model usr_u (.ref_clk(ref_clk), .rot_fwd_pin(rot_fwd_pin), .rot_back_pin(rot_back_pin),
      .press_pin(press_pin));
   ptc_transport #(.MS_CNT(8), .SPEED(2)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .rot_fwd_pin(rot_fwd_pin), .rot_back_pin(rot_back_pin), .press_pin(press_pin), .meta(meta),
      .disp(disp), .state_code(state_code), .track(track), .pos_ms(pos_ms), .audio_en(audio_en),
      .enter_dir(enter_dir), .activate_list(activate_list));
   always @(posedge ref_clk)
   begin
      n_dir += (enter_dir === 1'b1);
      n_list += (activate_list === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Rotate by the shorter way round to the wanted code
   task automatic sel(input int code);
      int d;
      d = (code - cur + 7) % 7;
      if (d <= 3)
         repeat (d) usr_u.step(1'b1);
      else
         repeat (7 - d) usr_u.step(1'b0);
      cur = code;
      repeat (5) @(negedge ref_clk);
      `CHK("disp.code", code[2:0], disp.code)
   endtask
   task automatic act(input int code);
      sel(code);
      usr_u.push();
      @(negedge ref_clk);
   endtask
   task automatic wait_st(input logic [2:0] s);
      int k;
      k = 0;
      while (state_code !== s && k < 2000)
      begin
         @(negedge ref_clk);
         k++;
      end
      if (k == 2000)
      begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic wait_pos(input logic [23:0] p);
      int k;
      k = 0;
      while (pos_ms !== p && k < 2000)
      begin
         @(negedge ref_clk);
         k++;
      end
      if (k == 2000)
      begin
         n_errors++;
         test_done();
      end
   endtask
   // Cycles between two position ticks
   task automatic period(output int n);
      logic [23:0] p;
      int k;
      k = 0;
      p = pos_ms;
      while (pos_ms === p && k < 100)
      begin
         @(negedge ref_clk);
         k++;
      end
      n = 0;
      p = pos_ms;
      while (pos_ms === p && n < 100)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   initial
   begin
      meta <= '{track_count: 8'h03, track_len: 24'h000099, sel_kind: SEL_SONG,
                artist: "ARTIST NAME LONG", title: "A VERY LONG SONG"};
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK("state_code", 3'h0, state_code)
      `CHK("state_txt", TXT_IDLE, disp.state_txt)
      `CHK("title", meta.title[127:40], disp.title)
      `CHK("artist", meta.artist[127:40], disp.artist)
      `CHK("time", POS_ZERO, disp.time_ms)
      usr_u.both();
      repeat (5) @(negedge ref_clk);
      `CHK("code held", 3'h0, disp.code)
      sel(6);
      sel(0);
      foreach (rows[i])
      begin
         act(rows[i].act);
         `CHK("state_code", rows[i].st, state_code)
         `CHK("audio_en", rows[i].au, audio_en)
         `CHK("track", rows[i].trk, track)
         `CHK("state_txt", txt[rows[i].st], disp.state_txt)
      end
      `CHK("pos stop", 24'h000000, pos_ms)
      act(ACT_PLAY);
      wait_st(3'h0);
      `CHK("pos end", meta.track_len, pos_ms)
      `CHK("time end", meta.track_len, disp.time_ms)
      act(ACT_REV);
      period(per);
      `CHK("rev period", 4, per)
      wait_st(3'h0);
      `CHK("pos start", 24'h000000, pos_ms)
      act(ACT_FF);
      period(per);
      `CHK("ff period", 4, per)
      act(ACT_STOP);
      `CHK("ff stop", 3'h0, state_code)
      act(ACT_STOP);
      `CHK("idle stop", 24'h000000, pos_ms)
      act(ACT_RPT);
      period(per);
      `CHK("play period", 8, per)
      wait_pos(meta.track_len);
      @(negedge ref_clk);
      `CHK("repeat loop", 3'h2, state_code)
      `CHK("wrapped", 24'h000000, pos_ms)
      act(ACT_STOP);
      @(posedge ref_clk);
      meta.sel_kind <= SEL_DIR;
      act(ACT_PLAY);
      `CHK("enter_dir", 1, n_dir)
      @(posedge ref_clk);
      meta.sel_kind <= SEL_LIST;
      act(ACT_PLAY);
      `CHK("activate_list", 1, n_list)
      `CHK("list idle", 3'h0, state_code)
      test_done();
   end
endmodule
`default_nettype wire
